// *** pnp_config_register_bank.sv ***
// Plug-and-play card-control and logical-device resource registers.
// Assumes an image-word stream from an EEPROM reader and a resource byte feeder.
//
// What this block does
// (RL1) The 8-bit checksum covers image words 0 to 0x1a, the first 54 bytes.
// (RL2) The 16-bit checksum in word 6 covers words 0 to 5 plus word 7.
// (RL3) Word 0x19 holds the vendor byte low and the 8-bit checksum high.
// (RL4) Writing the clear-number command bit clears the card select number.
// (RL5) Writing the wait-key command bit returns the state machine to wait-for-key.
// (RL6) Writing the reset-all command bit resets every logical device.
// (RL7) A wake write matching the card select number wakes the card.
// (RL8) The resource byte register returns the next pending fetched byte.
// (RL9) Status bit 0 reports that a resource byte is available.
// (RL10) The read-data port address written by the host is kept and used.
// (RL11) The isolation register takes part in serial isolation.
// (RL12) The card select number is held readable and writable.
// (RL13) Activation bit 0 enables the logical device; clearing it disables it.
// (RL14) Range-check bits 1:0 enable the range check; other bits read zero.
// (RL15) I/O base select splits high bit 0 and low bits 7:5; high bit 1 reads one.
// (RL16) ROM base select splits likewise; high bits 3:2 read as ones.
// (RL17) ROM size splits likewise with high bits 7:1 ones; wide flag in control bit 1.
// (RL18) Shared memory base select splits likewise; high bits 3:2 read as ones.
// (RL19) Shared memory size splits likewise; wide flag in control bit 1.
// (RL20) Vendor byte holds five option bits 4:0; bits 7:5 read zero.
// (RL21) Interrupt polarity reads as the complement of the interrupt type bit.
// (RL22) The interrupt line is not driven until the activation bit is set.
// (RL23) Image words are stored bit-reversed and are reversed back on load.
// (RL24) Resource registers load from image words 0x10 to 0x19, low byte first.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module pnp_config_register_bank
  import pnp_cfg_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [7:0]    reg_rdata,
  input  wire image_word_s   image_word,
  input  wire logic          image_done,
  input  wire logic          key_seen,
  input  wire logic          isolate_bit_in,
  input  wire logic [7:0]    res_byte_in,
  input  wire logic          res_byte_valid,
  output logic               res_byte_taken,
  input  wire logic          irq_event,
  output logic               irq_out,
  output logic               irq_oe,
  output logic [7:0]         read_port_addr,
  output pnp_state_e         pnp_state,
  output resource_cfg_s      cfg,
  output logic               checksum_ok,
  output logic               sum16_ok
);

  // ************************************************************
  // Register state
  // ************************************************************
  logic [7:0]    read_port_r;
  logic [7:0]    csn_r;
  pnp_state_e    state_r;
  logic          isolate_r;
  logic [7:0]    res_byte_r;
  logic          res_avail_r;
  logic [1:0]    range_r;
  resource_cfg_s cfg_r;
  logic [7:0]    sum8_r;
  logic [15:0]   sum16_r;
  logic [15:0]   sum16_stored_r;
  logic [7:0]    sum8_stored_r;
  logic          loaded_r;
  logic [15:0]   word_nat;
  logic          wr_ctl;
  logic          wr_wake;
  logic          rd_res;
  logic          rst_dev;
  logic          first_word;

  assign word_nat = bit_reverse16(image_word.data); // RL23
  assign wr_ctl   = reg_wr && (reg_addr == ADDR_CFG_CONTROL);
  assign wr_wake  = reg_wr && (reg_addr == ADDR_WAKE);
  assign rd_res   = reg_rd && (reg_addr == ADDR_RES_BYTE);
  assign rst_dev  = wr_ctl && reg_wdata[BIT_RST_ALL];
  // Word 0 opens a new image, so both sums restart there instead of adding to the last load.
  assign first_word = (image_word.addr == '0);

  // ************************************************************
  // Card control
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      read_port_r <= 8'h00;
    end else if (reg_wr && reg_addr == ADDR_READ_PORT) begin
      read_port_r <= reg_wdata; // RL10
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      csn_r <= CSN_RESET;
    end else if (wr_ctl && reg_wdata[BIT_CLR_CSN]) begin
      csn_r <= CSN_RESET; // RL4
    end else if (reg_wr && reg_addr == ADDR_CSN) begin
      csn_r <= reg_wdata; // RL12
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= ST_WAIT_KEY;
    end else if (wr_ctl && reg_wdata[BIT_WAIT_KEY]) begin
      state_r <= ST_WAIT_KEY; // RL5
    end else begin
      unique case (state_r)
        ST_WAIT_KEY: if (key_seen) state_r <= ST_SLEEP;
        ST_SLEEP: begin
          if (wr_wake && reg_wdata == csn_r) begin
            state_r <= (csn_r == CSN_RESET) ? ST_ISOLATE : ST_CONFIG; // RL7
          end
        end
        ST_ISOLATE: begin
          if (reg_wr && reg_addr == ADDR_CSN) state_r <= ST_CONFIG;
          else if (wr_wake && reg_wdata != csn_r) state_r <= ST_SLEEP;
        end
        ST_CONFIG: if (wr_wake && reg_wdata != csn_r) state_r <= ST_SLEEP;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      isolate_r <= 1'b0;
    end else if (state_r == ST_ISOLATE && reg_rd && reg_addr == ADDR_ISOLATION) begin
      isolate_r <= isolate_bit_in; // RL11
    end
  end

  // ************************************************************
  // Resource_byte
  // ************************************************************
  assign res_byte_taken = res_byte_valid && (!res_avail_r || rd_res);

  always_ff @(posedge mclk) begin
    if (rst) begin
      res_byte_r  <= 8'h00;
      res_avail_r <= 1'b0;
    end else if (res_byte_taken) begin
      res_byte_r  <= res_byte_in; // RL8
      res_avail_r <= 1'b1; // RL9
    end else if (rd_res) begin
      res_avail_r <= 1'b0; // RL9
    end
  end

  // ************************************************************
  // Logical device resources
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (rst || rst_dev) begin // RL6
      range_r <= 2'b00;
    end else if (reg_wr && reg_addr == ADDR_RANGE) begin
      range_r <= reg_wdata[1:0]; // RL14
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || rst_dev) begin // RL6
      cfg_r          <= '0;
      cfg_r.irq_sel  <= IRQ_RESET;
      cfg_r.dma_sel  <= DMA_RESET;
      cfg_r.vendor   <= VENDOR_RESET;
      cfg_r.io_base  <= SEL_RESET;
    end else if (image_word.valid) begin
      unique case (image_word.addr) // RL24
        WORD_RES_FIRST: begin
          cfg_r.io_base <= {word_nat[0], word_nat[15:13]};
        end
        7'h11: begin
          cfg_r.irq_sel        <= word_nat[3:0];
          cfg_r.irq_level_mode <= word_nat[8];
        end
        7'h12: cfg_r.dma_sel <= word_nat[2:0];
        7'h13: cfg_r.rom_base <= {word_nat[0], word_nat[15:13]};
        7'h14: begin
          cfg_r.rom_wide    <= word_nat[BIT_WIDE];
          cfg_r.rom_size[3] <= word_nat[8];
        end
        7'h15: cfg_r.rom_size[2:0] <= word_nat[7:5];
        7'h16: cfg_r.mem_base <= {word_nat[0], word_nat[15:13]};
        7'h17: begin
          cfg_r.mem_wide    <= word_nat[BIT_WIDE];
          cfg_r.mem_size[3] <= word_nat[8];
        end
        7'h18: cfg_r.mem_size[2:0] <= word_nat[7:5];
        WORD_VENDOR: cfg_r.vendor <= word_nat[4:0]; // RL3
        default: ;
      endcase
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_ACTIVATE:   cfg_r.active <= reg_wdata[0]; // RL13
        ADDR_IO_BASE_H:  cfg_r.io_base[3] <= reg_wdata[0]; // RL15
        ADDR_IO_BASE_L:  cfg_r.io_base[2:0] <= reg_wdata[7:5]; // RL15
        ADDR_IRQ_LEVEL:  cfg_r.irq_sel <= reg_wdata[3:0];
        ADDR_IRQ_TYPE:   cfg_r.irq_level_mode <= reg_wdata[0];
        ADDR_DMA:        cfg_r.dma_sel <= reg_wdata[2:0];
        ADDR_ROM_BASE_H: cfg_r.rom_base[3] <= reg_wdata[0]; // RL16
        ADDR_ROM_BASE_L: cfg_r.rom_base[2:0] <= reg_wdata[7:5]; // RL16
        ADDR_ROM_CTRL:   cfg_r.rom_wide <= reg_wdata[BIT_WIDE]; // RL17
        ADDR_ROM_SIZE_H: cfg_r.rom_size[3] <= reg_wdata[0]; // RL17
        ADDR_ROM_SIZE_L: cfg_r.rom_size[2:0] <= reg_wdata[7:5]; // RL17
        ADDR_MEM_BASE_H: cfg_r.mem_base[3] <= reg_wdata[0]; // RL18
        ADDR_MEM_BASE_L: cfg_r.mem_base[2:0] <= reg_wdata[7:5]; // RL18
        ADDR_MEM_CTRL:   cfg_r.mem_wide <= reg_wdata[BIT_WIDE]; // RL19
        ADDR_MEM_SIZE_H: cfg_r.mem_size[3] <= reg_wdata[0]; // RL19
        ADDR_MEM_SIZE_L: cfg_r.mem_size[2:0] <= reg_wdata[7:5]; // RL19
        ADDR_VENDOR:     cfg_r.vendor <= reg_wdata[4:0]; // RL20
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Image checksums
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      sum8_r         <= 8'h00;
      sum16_r        <= 16'h0000;
      sum16_stored_r <= 16'h0000;
      sum8_stored_r  <= 8'h00;
      loaded_r       <= 1'b0;
    end else if (image_word.valid) begin
      loaded_r <= 1'b0;
      if (image_word.addr <= WORD_SUM_LAST) begin
        if (image_word.addr == WORD_VENDOR) begin
          sum8_stored_r <= word_nat[15:8]; // RL3
        end
        sum8_r <= (first_word ? 8'h00 : sum8_r) + word_nat[7:0] + word_nat[15:8]; // RL1
      end
      if (image_word.addr <= WORD_SUM16_END || image_word.addr == WORD_SUM16_ADD) begin
        sum16_r <= (first_word ? 16'h0000 : sum16_r) + word_nat; // RL2
      end
      if (image_word.addr == WORD_SUM16) begin
        sum16_stored_r <= word_nat; // RL2
      end
    end else if (image_done) begin
      loaded_r <= 1'b1;
    end
  end

  assign checksum_ok = loaded_r && (sum8_r == 8'h00); // RL1
  assign sum16_ok    = loaded_r && (sum16_r == sum16_stored_r); // RL2

  // ************************************************************
  // Interrupt pin
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_out <= 1'b0;
      irq_oe  <= 1'b0;
    end else begin
      irq_oe  <= cfg_r.active; // RL22
      irq_out <= cfg_r.irq_level_mode ? !irq_event : irq_event; // RL21
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_ISOLATION:  reg_rdata <= {7'h00, isolate_bit_in}; // RL11
        ADDR_RES_BYTE:   reg_rdata <= res_byte_r; // RL8
        ADDR_RES_STATUS: reg_rdata <= {7'h00, res_avail_r}; // RL9
        ADDR_CSN:        reg_rdata <= csn_r; // RL12
        ADDR_ACTIVATE:   reg_rdata <= {7'h00, cfg_r.active}; // RL13
        ADDR_RANGE:      reg_rdata <= {6'h00, range_r}; // RL14
        ADDR_IO_BASE_H:  reg_rdata <= IO_HIGH_ONES | {7'h00, cfg_r.io_base[3]}; // RL15
        ADDR_IO_BASE_L:  reg_rdata <= low_part(cfg_r.io_base); // RL15
        ADDR_IRQ_LEVEL:  reg_rdata <= {4'h0, cfg_r.irq_sel};
        ADDR_IRQ_TYPE:   reg_rdata <= {6'h00, !cfg_r.irq_level_mode,
                                       cfg_r.irq_level_mode}; // RL21
        ADDR_DMA:        reg_rdata <= {5'h00, cfg_r.dma_sel};
        ADDR_ROM_BASE_H: reg_rdata <= BASE_HIGH_ONE | {7'h00, cfg_r.rom_base[3]}; // RL16
        ADDR_ROM_BASE_L: reg_rdata <= low_part(cfg_r.rom_base); // RL16
        ADDR_ROM_CTRL:   reg_rdata <= {6'h00, cfg_r.rom_wide, 1'b0}; // RL17
        ADDR_ROM_SIZE_H: reg_rdata <= SIZE_HIGH_ONE | {7'h00, cfg_r.rom_size[3]}; // RL17
        ADDR_ROM_SIZE_L: reg_rdata <= low_part(cfg_r.rom_size); // RL17
        ADDR_MEM_BASE_H: reg_rdata <= BASE_HIGH_ONE | {7'h00, cfg_r.mem_base[3]}; // RL18
        ADDR_MEM_BASE_L: reg_rdata <= low_part(cfg_r.mem_base); // RL18
        ADDR_MEM_CTRL:   reg_rdata <= {6'h00, cfg_r.mem_wide, 1'b0}; // RL19
        ADDR_MEM_SIZE_H: reg_rdata <= SIZE_HIGH_ONE | {7'h00, cfg_r.mem_size[3]}; // RL19
        ADDR_MEM_SIZE_L: reg_rdata <= low_part(cfg_r.mem_size); // RL19
        ADDR_VENDOR:     reg_rdata <= {3'h0, cfg_r.vendor}; // RL20
        default:         reg_rdata <= 8'h00;
      endcase
    end
  end

  assign read_port_addr = read_port_r; // RL10
  assign pnp_state      = state_r;
  assign cfg            = cfg_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  a_clear_csn_zero: assert property (@(posedge mclk) disable iff (rst) // RL4
    (reg_wr && reg_addr == ADDR_CFG_CONTROL && reg_wdata[BIT_CLR_CSN]) |=> csn_r == 8'h00)
    else $error("card select number not cleared");
  a_wait_key_back: assert property (@(posedge mclk) disable iff (rst) // RL5
    (reg_wr && reg_addr == ADDR_CFG_CONTROL && reg_wdata[BIT_WAIT_KEY])
    |=> state_r == ST_WAIT_KEY)
    else $error("state not returned to wait for key");
  a_reset_all_dev: assert property (@(posedge mclk) disable iff (rst) // RL6
    (reg_wr && reg_addr == ADDR_CFG_CONTROL && reg_wdata[BIT_RST_ALL])
    |=> !cfg_r.active && range_r == 2'b00)
    else $error("logical device not reset");
  a_wake_match: assert property (@(posedge mclk) disable iff (rst) // RL7
    (state_r == ST_SLEEP && !wr_ctl && wr_wake && reg_wdata == csn_r) |=> state_r != ST_SLEEP)
    else $error("wake on matching number failed");
  a_status_avail: assert property (@(posedge mclk) disable iff (rst) // RL9
    (reg_rd && reg_addr == ADDR_RES_STATUS) |=> reg_rdata[0] == $past(res_avail_r))
    else $error("status bit wrong");
  a_polarity_comp: assert property (@(posedge mclk) disable iff (rst) // RL21
    (reg_rd && reg_addr == ADDR_IRQ_TYPE) |=> reg_rdata[1] == !reg_rdata[0])
    else $error("polarity not complement of type");
  a_irq_quiet_off: assert property (@(posedge mclk) disable iff (rst) // RL22
    !cfg_r.active [*2] |-> !irq_oe)
    else $error("interrupt driven while inactive");
  a_io_high_ones: assert property (@(posedge mclk) disable iff (rst) // RL15
    (reg_rd && reg_addr == ADDR_IO_BASE_H) |=> reg_rdata[7:1] == 7'h01)
    else $error("io base high constant bits wrong");
  a_vendor_upper: assert property (@(posedge mclk) disable iff (rst) // RL20
    (reg_rd && reg_addr == ADDR_VENDOR) |=> reg_rdata[7:5] == 3'h0)
    else $error("vendor upper bits not zero");
  a_read_port_kept: assert property (@(posedge mclk) disable iff (rst) // RL10
    (reg_wr && reg_addr == ADDR_READ_PORT) |=> read_port_addr == $past(reg_wdata))
    else $error("read port address not kept");

  c_wake_config: cover property (@(posedge mclk) state_r == ST_SLEEP ##1 state_r == ST_CONFIG);
  c_res_read: cover property (@(posedge mclk) res_avail_r && rd_res);
  c_image_ok: cover property (@(posedge mclk) checksum_ok);
  c_active_irq: cover property (@(posedge mclk) irq_oe);

endmodule : pnp_config_register_bank

// *** pnp_cfg_pkg.sv ***
// Constants, types and register map of the plug-and-play configuration bank.
// Assumes an 8-bit register port clocked by mclk with synchronous reset.
package pnp_cfg_pkg;

  // ************************************************************
  // Register indices
  // ************************************************************
  localparam logic [7:0] ADDR_READ_PORT   = 8'h00;
  localparam logic [7:0] ADDR_ISOLATION   = 8'h01;
  localparam logic [7:0] ADDR_CFG_CONTROL = 8'h02;
  localparam logic [7:0] ADDR_WAKE        = 8'h03;
  localparam logic [7:0] ADDR_RES_BYTE    = 8'h04;
  localparam logic [7:0] ADDR_RES_STATUS  = 8'h05;
  localparam logic [7:0] ADDR_CSN         = 8'h06;
  localparam logic [7:0] ADDR_LDN         = 8'h07;
  localparam logic [7:0] ADDR_ACTIVATE    = 8'h30;
  localparam logic [7:0] ADDR_RANGE       = 8'h31;
  localparam logic [7:0] ADDR_ROM_BASE_H  = 8'h40;
  localparam logic [7:0] ADDR_ROM_BASE_L  = 8'h41;
  localparam logic [7:0] ADDR_ROM_CTRL    = 8'h42;
  localparam logic [7:0] ADDR_ROM_SIZE_H  = 8'h43;
  localparam logic [7:0] ADDR_ROM_SIZE_L  = 8'h44;
  localparam logic [7:0] ADDR_MEM_BASE_H  = 8'h48;
  localparam logic [7:0] ADDR_MEM_BASE_L  = 8'h49;
  localparam logic [7:0] ADDR_MEM_CTRL    = 8'h4a;
  localparam logic [7:0] ADDR_MEM_SIZE_H  = 8'h4b;
  localparam logic [7:0] ADDR_MEM_SIZE_L  = 8'h4c;
  localparam logic [7:0] ADDR_IO_BASE_H   = 8'h60;
  localparam logic [7:0] ADDR_IO_BASE_L   = 8'h61;
  localparam logic [7:0] ADDR_IRQ_LEVEL   = 8'h70;
  localparam logic [7:0] ADDR_IRQ_TYPE    = 8'h71;
  localparam logic [7:0] ADDR_DMA         = 8'h74;
  localparam logic [7:0] ADDR_VENDOR      = 8'hf0;

  // ************************************************************
  // Field positions and constant read bits
  // ************************************************************
  localparam int          BIT_RST_ALL   = 0;
  localparam int          BIT_WAIT_KEY  = 1;
  localparam int          BIT_CLR_CSN   = 2;
  localparam int          BIT_WIDE      = 1;
  localparam logic [7:0]  IO_HIGH_ONES  = 8'h02;
  localparam logic [7:0]  BASE_HIGH_ONE = 8'h0c;
  localparam logic [7:0]  SIZE_HIGH_ONE = 8'hfe;
  localparam logic [4:0]  VENDOR_RESET  = 5'h00;
  localparam logic [3:0]  IRQ_RESET     = 4'h3;
  localparam logic [2:0]  DMA_RESET     = 3'h3;
  localparam logic [3:0]  SEL_RESET     = 4'h0;
  localparam logic [7:0]  CSN_RESET     = 8'h00;

  // ************************************************************
  // Image layout
  // ************************************************************
  localparam logic [6:0]  WORD_RES_FIRST = 7'h10;
  localparam logic [6:0]  WORD_VENDOR    = 7'h19;
  localparam logic [6:0]  WORD_SUM_LAST  = 7'h1a;
  localparam logic [6:0]  WORD_SUM16     = 7'h06;
  localparam logic [6:0]  WORD_SUM16_END = 7'h05;
  localparam logic [6:0]  WORD_SUM16_ADD = 7'h07;
  localparam int          SUM_BYTES      = 54;

  typedef enum logic [1:0] {
    ST_WAIT_KEY = 2'b00,
    ST_SLEEP    = 2'b01,
    ST_ISOLATE  = 2'b11,
    ST_CONFIG   = 2'b10
  } pnp_state_e;

  typedef struct packed {
    logic [6:0]  addr;
    logic [15:0] data;
    logic        valid;
  } image_word_s;

  typedef struct packed {
    logic        active;
    logic [3:0]  io_base;
    logic [3:0]  irq_sel;
    logic        irq_level_mode;
    logic [2:0]  dma_sel;
    logic [3:0]  rom_base;
    logic [3:0]  rom_size;
    logic        rom_wide;
    logic [3:0]  mem_base;
    logic [3:0]  mem_size;
    logic        mem_wide;
    logic [4:0]  vendor;
  } resource_cfg_s;

  // Undoes the bit-reversed storage of an image word.
  function automatic logic [15:0] bit_reverse16(input logic [15:0] w);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = w[15-i];
    end
    return r;
  endfunction : bit_reverse16

  // Places bits 2:0 of a 4-bit select into a low-register image at bits 7:5.
  function automatic logic [7:0] low_part(input logic [3:0] f);
    return {f[2:0], 5'h00};
  endfunction : low_part

endpackage : pnp_cfg_pkg

// *** pnp_image_source.sv ***
// Model of the serial image reader that feeds the bank with stored words.
// Assumes the bank package; a start pulse streams words 0 to 0x1a, one each cycle.
`timescale 1ns/1ps
module pnp_image_source
  import pnp_cfg_pkg::*;
#(
  parameter logic [143:0] RES_WORDS = '0,
  parameter logic [7:0]   VENDOR    = 8'h00
)(
  input  wire logic  mclk,
  input  wire logic  rst,
  input  wire logic  start,
  input  wire logic  corrupt,
  output image_word_s image_word,
  output logic       image_done
);
  // ************************************************************
  // Image content and streaming
  // ************************************************************
  logic [15:0] img [0:26];
  logic [15:0] plain;
  logic [15:0] s16;
  logic [7:0]  s8;
  logic [5:0]  idx_r;
  logic        run_r;

  always_comb begin
    s16 = 16'h0000;
    s8  = 8'h00;
    for (int i = 0; i < 27; i++) img[i] = {8'(i) ^ 8'h5a, 8'(i)};
    for (int i = 0; i < 9; i++) img[16+i] = RES_WORDS[i*16 +: 16];
    img[25] = {8'h00, VENDOR};
    for (int i = 0; i < 8; i++) if (i != 6) s16 = s16 + img[i];
    img[6] = s16;
    for (int i = 0; i < 27; i++) s8 = s8 + img[i][7:0] + img[i][15:8];
    img[25][15:8] = 8'h00 - s8;
  end

  assign plain = img[idx_r] ^ {15'h0000, corrupt && idx_r == 6'd3};

  always_comb begin
    image_word.addr  = {1'b0, idx_r};
    image_word.valid = run_r;
    for (int b = 0; b < 16; b++) image_word.data[b] = plain[15-b];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      run_r      <= 1'b0;
      idx_r      <= 6'd0;
      image_done <= 1'b0;
    end else begin
      image_done <= run_r && idx_r == 6'd26;
      if (start) begin
        run_r <= 1'b1;
        idx_r <= 6'd0;
      end else if (run_r && idx_r == 6'd26) begin
        run_r <= 1'b0;
      end else if (run_r) begin
        idx_r <= idx_r + 6'd1;
      end
    end
  end
endmodule : pnp_image_source

// *** pnp_config_register_bank_tb_top.sv ***
// Self-checking bench of the plug-and-play register bank.
// Assumes the bank package and the image source model in the same folder.
`timescale 1ns/1ps
module pnp_config_register_bank_tb_top
  import pnp_cfg_pkg::*;
;
  // ************************************************************
  // Signals and tables
  // ************************************************************
  localparam logic [143:0] RES = {16'h0020, 16'h0000, 16'h6000, 16'h00e0, 16'h0102,
                                  16'h4001, 16'h0005, 16'h0105, 16'ha001};
  logic          mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic          key_seen = 1'b0, isolate_bit_in = 1'b0, res_byte_valid = 1'b0;
  logic          irq_event = 1'b0, start = 1'b0, corrupt = 1'b0;
  logic [7:0]    reg_addr = 8'h00, reg_wdata = 8'h00, res_byte_in = 8'h00;
  logic [7:0]    reg_rdata, read_port_addr;
  logic          res_byte_taken, irq_out, irq_oe, image_done, checksum_ok, sum16_ok;
  image_word_s   image_word;
  pnp_state_e    pnp_state;
  resource_cfg_s cfg;
  int            fail_count = 0, comparisons = 0, cycles = 0;
  logic [7:0] ld_a [0:15] = '{8'h60, 8'h61, 8'h70, 8'h71, 8'h74, 8'h40, 8'h41, 8'h42,
                              8'h43, 8'h44, 8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4c, 8'hf0};
  logic [7:0] ld_e [0:15] = '{8'h03, 8'ha0, 8'h05, 8'h01, 8'h05, 8'h0d, 8'h40, 8'h02,
                              8'hff, 8'he0, 8'h0c, 8'h60, 8'h00, 8'hfe, 8'h20, 8'h15};
  logic [7:0] mk_a [0:16] = '{8'h60, 8'h61, 8'h31, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44,
                              8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4c, 8'hf0, 8'h70, 8'h71, 8'h74};
  logic [7:0] mk_f [0:16] = '{8'h03, 8'he0, 8'h03, 8'h0d, 8'he0, 8'h02, 8'hff, 8'he0,
                              8'h0d, 8'he0, 8'h02, 8'hff, 8'he0, 8'h1f, 8'h0f, 8'h01, 8'h07};
  logic [7:0] mk_z [0:16] = '{8'h02, 8'h00, 8'h00, 8'h0c, 8'h00, 8'h00, 8'hfe, 8'h00,
                              8'h0c, 8'h00, 8'h00, 8'hfe, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};

  pnp_config_register_bank pnp_config_register_bank_inst (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .image_word(image_word),
    .image_done(image_done), .key_seen(key_seen), .isolate_bit_in(isolate_bit_in),
    .res_byte_in(res_byte_in), .res_byte_valid(res_byte_valid),
    .res_byte_taken(res_byte_taken), .irq_event(irq_event), .irq_out(irq_out),
    .irq_oe(irq_oe), .read_port_addr(read_port_addr), .pnp_state(pnp_state), .cfg(cfg),
    .checksum_ok(checksum_ok), .sum16_ok(sum16_ok));

  pnp_image_source #(.RES_WORDS(RES), .VENDOR(8'h15)) pnp_image_source_inst (
    .mclk(mclk), .rst(rst), .start(start), .corrupt(corrupt),
    .image_word(image_word), .image_done(image_done));

  // ************************************************************
  // Clock, watchdog and access tasks
  // ************************************************************
  always #4 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, want);
  endtask : rd

  task automatic load(input logic bad);
    @(posedge mclk);
    corrupt <= bad;
    start   <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    for (int n = 0; n < 40 && image_done !== 1'b1; n++) tick();
    tick();
  endtask : load

  task automatic state_is(input pnp_state_e s);
    tick();
    chk(8'(pnp_state), 8'(s));
  endtask : state_is

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    load(1'b1);
    chk(8'(checksum_ok), 8'h00);
    chk(8'(sum16_ok), 8'h00);
    load(1'b0);
    chk(8'(checksum_ok), 8'h01);
    chk(8'(sum16_ok), 8'h01);
    chk(8'(cfg.io_base), 8'h0d);
    foreach (ld_a[i]) rd(ld_a[i], ld_e[i]);
    @(posedge mclk);
    key_seen <= 1'b1;
    @(posedge mclk);
    key_seen <= 1'b0;
    wr(ADDR_WAKE, 8'h00);
    state_is(ST_ISOLATE);
    isolate_bit_in <= 1'b1;
    rd(ADDR_ISOLATION, 8'h01);
    wr(ADDR_CSN, 8'h07);
    state_is(ST_CONFIG);
    rd(ADDR_CSN, 8'h07);
    wr(ADDR_WAKE, 8'h03);
    state_is(ST_SLEEP);
    wr(ADDR_WAKE, 8'h07);
    state_is(ST_CONFIG);
    wr(ADDR_READ_PORT, 8'h83);
    rd(ADDR_READ_PORT, 8'h00);
    chk(read_port_addr, 8'h83);
    rd(ADDR_LDN, 8'h00);
    rd(8'h20, 8'h00);
    rd(ADDR_RES_STATUS, 8'h00);
    @(posedge mclk);
    res_byte_in    <= 8'h5a;
    res_byte_valid <= 1'b1;
    #1 chk(8'(res_byte_taken), 8'h01);
    @(posedge mclk);
    res_byte_valid <= 1'b0;
    rd(ADDR_RES_STATUS, 8'h01);
    rd(ADDR_RES_BYTE, 8'h5a);
    rd(ADDR_RES_STATUS, 8'h00);
    foreach (mk_a[i]) begin
      wr(mk_a[i], 8'hff);
      rd(mk_a[i], mk_f[i]);
      wr(mk_a[i], 8'h00);
      rd(mk_a[i], mk_z[i]);
    end
    irq_event <= 1'b1;
    wr(ADDR_IRQ_TYPE, 8'h01);
    tick();
    chk(8'(irq_oe), 8'h00);
    wr(ADDR_ACTIVATE, 8'h01);
    tick();
    chk(8'(irq_oe), 8'h01);
    chk(8'(irq_out), 8'h00);
    rd(ADDR_ACTIVATE, 8'h01);
    wr(ADDR_ACTIVATE, 8'h00);
    tick();
    chk(8'(irq_oe), 8'h00);
    wr(ADDR_ACTIVATE, 8'h01);
    wr(ADDR_RANGE, 8'h03);
    wr(ADDR_CFG_CONTROL, 8'h01);
    rd(ADDR_ACTIVATE, 8'h00);
    rd(ADDR_RANGE, 8'h00);
    rd(ADDR_IRQ_LEVEL, {4'h0, IRQ_RESET});
    rd(ADDR_DMA, {5'h00, DMA_RESET});
    wr(ADDR_CFG_CONTROL, 8'h04);
    rd(ADDR_CSN, 8'h00);
    wr(ADDR_CFG_CONTROL, 8'h02);
    state_is(ST_WAIT_KEY);
    final_report();
  end
endmodule : pnp_config_register_bank_tb_top
